// [rtl/cfb_core_cfg.svh]
// Constants of the core flag and bank pointer block: offsets, fields, reset values.
`ifndef CFB_CORE_CFG_SVH
`define CFB_CORE_CFG_SVH
`define CFB_OFF_BANK_SEL 8'h00
`define CFB_OFF_PC_LOW 8'h04
`define CFB_OFF_TPTR_LO 8'h08
`define CFB_OFF_TPTR_HI 8'h0C
`define CFB_OFF_TREAD_HI 8'h10
`define CFB_OFF_FLAGS 8'h14
`define CFB_OFF_OP 8'h18
`define CFB_OFF_RESULT 8'h1C
`define CFB_OFF_CMD 8'h20
`define CFB_OFF_PC 8'h24
`define CFB_OFF_WORK 8'h28
`define CFB_OFF_JUMP 8'h2C
`define CFB_OFF_MEM 8'h30
`define CFB_OFF_STATE 8'h34
`define CFB_CMD_WATCHDOG_CLEAR_INSTR 0
`define CFB_CMD_HALT 1
`define CFB_CMD_TREAD 2
`define CFB_CMD_STEP 3
`define CFB_OP_LSB 8
`define CFB_MEM_ADDR_LSB 16
`define CFB_RST_BANK 8'h00
`define CFB_RST_PC 16'h0000
`define CFB_FLAG_WR_MASK 8'h0F
`define CFB_RESP_OK 2'h0
`define CFB_RESP_ERR 2'h2
`endif

// [rtl/cfb_core_pkg.sv]
// Types shared by the core flag and bank pointer block.
package cfb_core_pkg;
   typedef enum logic [3:0] {
      CFB_OP_ADD = 4'h0,
      CFB_OP_ADC = 4'h1,
      CFB_OP_SUB = 4'h2,
      CFB_OP_SBC = 4'h3,
      CFB_OP_AND = 4'h4,
      CFB_OP_OR = 4'h5,
      CFB_OP_XOR = 4'h6,
      CFB_OP_RLC = 4'h7,
      CFB_OP_RRC = 4'h8,
      CFB_OP_MOVA = 4'h9,
      CFB_OP_MOVM = 4'hA
   } cfb_op_t;

   typedef struct packed {
      logic sign_xor_flag;
      logic borrow_chain_null;
      logic sign_wrap_flag;
      logic zero;
      logic half_bit_flag;
      logic carry;
   } cfb_arith_t;

   typedef struct packed {
      logic sign_xor_flag;
      logic borrow_chain_null;
      logic wdt_expired_flag;
      logic halted_flag;
      logic sign_wrap_flag;
      logic zero;
      logic half_bit_flag;
      logic carry;
   } cfb_flags_t;
endpackage

// [rtl/cfb_table_mem.sv]
// Program word store for table reads, with registered read data.
`timescale 1ns/1ps
`default_nettype none
module cfb_table_mem (
   // Clock
   input wire logic clk_sys,
   // Write port
   input wire logic wr_en,
   input wire logic [8:0] wr_addr,
   input wire logic [15:0] wr_data,
   // Read port
   input wire logic rd_en,
   input wire logic [8:0] rd_addr,
   output logic [15:0] rd_data
);
   logic [15:0] mem_r [0:511];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rd_en) begin
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule
`default_nettype wire

// [rtl/cfb_flag_alu.sv]
// Arithmetic and logic unit that forms the result and the new arithmetic flags.
`timescale 1ns/1ps
`default_nettype none
module cfb_flag_alu (
   // Operation
   input wire cfb_core_pkg::cfb_op_t op,
   input wire logic [7:0] work,
   input wire logic [7:0] operand,
   input wire cfb_core_pkg::cfb_arith_t flags_in,
   // Result
   output logic [7:0] result,
   output logic work_we,
   output cfb_core_pkg::cfb_arith_t flags_out
);
   logic is_sub;
   logic cin;
   logic [7:0] bb;
   logic [8:0] sum;
   logic [4:0] low;
   logic carry7;

   always_comb begin
      is_sub = (op == cfb_core_pkg::CFB_OP_SUB) || (op == cfb_core_pkg::CFB_OP_SBC);
      bb = is_sub ? ~operand : operand;
      cin = (op == cfb_core_pkg::CFB_OP_SUB) ||
            (((op == cfb_core_pkg::CFB_OP_ADC) || (op == cfb_core_pkg::CFB_OP_SBC)) &&
             flags_in.carry);
      sum = {1'b0, work} + {1'b0, bb} + {8'h00, cin};
      low = {1'b0, work[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      carry7 = work[7] ^ bb[7] ^ sum[7];
      flags_out = flags_in;
      work_we = 1'b1;
      result = sum[7:0];
      unique case (op)
         cfb_core_pkg::CFB_OP_ADD, cfb_core_pkg::CFB_OP_ADC,
         cfb_core_pkg::CFB_OP_SUB, cfb_core_pkg::CFB_OP_SBC: begin
            // A subtract adds the complement, so carry out means no borrow.
            flags_out.carry = sum[8];
            flags_out.half_bit_flag = low[4];
            flags_out.sign_wrap_flag = carry7 ^ sum[8];
         end
         cfb_core_pkg::CFB_OP_AND: result = work & operand;
         cfb_core_pkg::CFB_OP_OR: result = work | operand;
         cfb_core_pkg::CFB_OP_XOR: result = work ^ operand;
         cfb_core_pkg::CFB_OP_RLC: begin
            result = {work[6:0], flags_in.carry};
            flags_out.carry = work[7];
         end
         cfb_core_pkg::CFB_OP_RRC: begin
            result = {flags_in.carry, work[7:1]};
            flags_out.carry = work[0];
         end
         cfb_core_pkg::CFB_OP_MOVA: result = operand;
         cfb_core_pkg::CFB_OP_MOVM: begin
            result = work;
            work_we = 1'b0;
         end
         default: work_we = 1'b0;
      endcase
      if (op inside {cfb_core_pkg::CFB_OP_ADD, cfb_core_pkg::CFB_OP_ADC,
                     cfb_core_pkg::CFB_OP_SUB, cfb_core_pkg::CFB_OP_SBC,
                     cfb_core_pkg::CFB_OP_AND, cfb_core_pkg::CFB_OP_OR,
                     cfb_core_pkg::CFB_OP_XOR}) begin
         flags_out.zero = (result == 8'h00);
         flags_out.sign_xor_flag = flags_out.sign_wrap_flag ^ result[7];
      end
      if (op == cfb_core_pkg::CFB_OP_SUB) begin
         flags_out.borrow_chain_null = (result == 8'h00);
      end else if (op == cfb_core_pkg::CFB_OP_SBC) begin
         flags_out.borrow_chain_null = flags_in.borrow_chain_null & (result == 8'h00);
      end
   end
endmodule
`default_nettype wire

// [rtl/cfb_core_flags.sv]
// Core flag word, bank select, pc low byte and table read logic behind AXI4-Lite.
`include "cfb_core_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cfb_core_flags #(
   parameter int BANK_W = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Watchdog event
   input wire logic wdt_timeout,
   // Core view
   output logic [15:0] pc_out,
   output logic [7:0] bank_out,
   output logic dummy_cycle
);
   localparam logic [2:0] BANK_MASK = 3'((1 << BANK_W) - 1);

   logic aw_full_r, awready_r, w_full_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r, rd_mux;
   logic rd_hit, wr_hit;
   logic aw_full_nxt, w_full_nxt, rvalid_nxt;
   logic wr_go, wr_done, lane0;
   logic wr_bank, wr_pcl, wr_tlo, wr_thi, wr_flags, wr_op, wr_cmd, wr_jump, wr_mem;
   logic cmd_watchdog_clear_instr, cmd_halt, cmd_tread, cmd_step;
   logic [7:0] bank_sel_r, tptr_lo_r, tptr_hi_r, tread_hi_r, work_r, result_r;
   logic [15:0] pc_r;
   logic dummy_r, tread_pend_r, to_r, pdf_r;
   logic [15:0] mem_rdata;
   logic [2:0] bank_ext;
   cfb_core_pkg::cfb_arith_t arith_r, alu_flags;
   cfb_core_pkg::cfb_flags_t flag_word;
   cfb_core_pkg::cfb_op_t alu_op;
   logic [7:0] alu_result;
   logic alu_work_we;

   // Write channel: address and data are taken independently, in either order.
   assign wr_done = bvalid_r && s_axi_bready;
   assign aw_full_nxt = (aw_full_r && !wr_done) || (s_axi_awvalid && awready_r);
   assign w_full_nxt = (w_full_r && !wr_done) || (s_axi_wvalid && wready_r);
   assign wr_go = aw_full_r && w_full_r && !bvalid_r;
   assign lane0 = wr_go && w_strb_r[0];

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         aw_full_r <= 1'b0;
         awready_r <= 1'b0;
         w_full_r <= 1'b0;
         wready_r <= 1'b0;
      end else begin
         aw_full_r <= aw_full_nxt;
         awready_r <= !aw_full_nxt;
         w_full_r <= w_full_nxt;
         wready_r <= !w_full_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (s_axi_awvalid && awready_r) begin
         aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end
   end

   always_comb begin
      wr_hit = aw_addr_r inside {`CFB_OFF_BANK_SEL, `CFB_OFF_PC_LOW, `CFB_OFF_TPTR_LO,
                                 `CFB_OFF_TPTR_HI, `CFB_OFF_TREAD_HI, `CFB_OFF_FLAGS,
                                 `CFB_OFF_OP, `CFB_OFF_RESULT, `CFB_OFF_CMD, `CFB_OFF_PC,
                                 `CFB_OFF_WORK, `CFB_OFF_JUMP, `CFB_OFF_MEM, `CFB_OFF_STATE};
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bvalid_r <= 1'b0;
         bresp_r <= `CFB_RESP_OK;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? `CFB_RESP_OK : `CFB_RESP_ERR;
      end else if (wr_done) begin
         bvalid_r <= 1'b0;
      end
   end

   assign wr_bank = lane0 && (aw_addr_r == `CFB_OFF_BANK_SEL);
   assign wr_pcl = lane0 && (aw_addr_r == `CFB_OFF_PC_LOW);
   assign wr_tlo = lane0 && (aw_addr_r == `CFB_OFF_TPTR_LO);
   assign wr_thi = lane0 && (aw_addr_r == `CFB_OFF_TPTR_HI);
   assign wr_flags = lane0 && (aw_addr_r == `CFB_OFF_FLAGS);
   assign wr_op = wr_go && (&w_strb_r[1:0]) && (aw_addr_r == `CFB_OFF_OP);
   assign wr_cmd = lane0 && (aw_addr_r == `CFB_OFF_CMD);
   assign wr_jump = wr_go && (&w_strb_r[1:0]) && (aw_addr_r == `CFB_OFF_JUMP);
   assign wr_mem = wr_go && (&w_strb_r) && (aw_addr_r == `CFB_OFF_MEM);
   assign cmd_watchdog_clear_instr = wr_cmd && w_data_r[`CFB_CMD_WATCHDOG_CLEAR_INSTR];
   assign cmd_halt = wr_cmd && w_data_r[`CFB_CMD_HALT];
   assign cmd_tread = wr_cmd && w_data_r[`CFB_CMD_TREAD];
   assign cmd_step = wr_cmd && w_data_r[`CFB_CMD_STEP];

   // Read channel: one read at a time, data one cycle after the address is taken.
   assign rvalid_nxt = (rvalid_r && !s_axi_rready) || (s_axi_arvalid && arready_r);

   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (s_axi_araddr)
         `CFB_OFF_BANK_SEL: rd_mux[7:0] = bank_sel_r;
         `CFB_OFF_PC_LOW: rd_mux[7:0] = pc_r[7:0];
         `CFB_OFF_TPTR_LO: rd_mux[7:0] = tptr_lo_r;
         `CFB_OFF_TPTR_HI: rd_mux[7:0] = tptr_hi_r;
         `CFB_OFF_TREAD_HI: rd_mux[7:0] = tread_hi_r;
         `CFB_OFF_FLAGS: rd_mux[7:0] = flag_word;
         `CFB_OFF_RESULT: rd_mux[7:0] = result_r;
         `CFB_OFF_PC: rd_mux[15:0] = pc_r;
         `CFB_OFF_WORK: rd_mux[7:0] = work_r;
         `CFB_OFF_STATE: rd_mux[0] = dummy_r;
         `CFB_OFF_OP, `CFB_OFF_CMD, `CFB_OFF_JUMP, `CFB_OFF_MEM: rd_mux = 32'h0000_0000;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `CFB_RESP_OK;
      end else begin
         arready_r <= !rvalid_nxt;
         rvalid_r <= rvalid_nxt;
         if (s_axi_arvalid && arready_r) begin
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? `CFB_RESP_OK : `CFB_RESP_ERR;
         end
      end
   end

   // Bank select: low field picks the bank, upper bits are free storage.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bank_sel_r <= `CFB_RST_BANK;
      end else if (wr_bank) begin
         bank_sel_r <= w_data_r[7:0];
      end
   end

   // Bits above the chosen width never reach the pc, so they only store data.
   assign bank_ext = bank_sel_r[2:0] & BANK_MASK;

   // The flag word is not pushed on a call; software saves it when it matters.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pc_r <= `CFB_RST_PC;
      end else if (wr_jump) begin
         pc_r <= {bank_ext, w_data_r[12:0]};
      end else if (wr_pcl) begin
         pc_r[7:0] <= w_data_r[7:0];
      end else if (cmd_step && !dummy_r) begin
         pc_r <= pc_r + 16'h0001;
      end
   end

   // The dummy cycle covers the refetch after the low byte changed.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dummy_r <= 1'b0;
      end else begin
         dummy_r <= wr_pcl;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tptr_lo_r <= 8'h00;
         tptr_hi_r <= 8'h00;
      end else begin
         if (wr_tlo) begin
            tptr_lo_r <= w_data_r[7:0];
         end
         if (wr_thi) begin
            tptr_hi_r <= w_data_r[7:0];
         end
      end
   end

   cfb_table_mem u_mem (
      .clk_sys(clk_sys),
      .wr_en(wr_mem),
      .wr_addr(w_data_r[`CFB_MEM_ADDR_LSB +: 9]),
      .wr_data(w_data_r[15:0]),
      .rd_en(cmd_tread),
      .rd_addr({tptr_hi_r[0], tptr_lo_r}),
      .rd_data(mem_rdata)
   );

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tread_pend_r <= 1'b0;
         tread_hi_r <= 8'h00;
      end else begin
         tread_pend_r <= cmd_tread;
         if (tread_pend_r) begin
            tread_hi_r <= mem_rdata[15:8];
         end
      end
   end

   assign alu_op = cfb_core_pkg::cfb_op_t'(w_data_r[`CFB_OP_LSB +: 4]);

   cfb_flag_alu u_alu (
      .op(alu_op),
      .work(work_r),
      .operand(w_data_r[7:0]),
      .flags_in(arith_r),
      .result(alu_result),
      .work_we(alu_work_we),
      .flags_out(alu_flags)
   );

   // The work register is the only path between two general registers.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         work_r <= 8'h00;
         result_r <= 8'h00;
      end else if (wr_op) begin
         result_r <= alu_result;
         if (alu_work_we) begin
            work_r <= alu_result;
         end
      end else if (tread_pend_r) begin
         work_r <= mem_rdata[7:0];
      end
   end

   // Only the low four flags accept software data; the sign xor is computed.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         arith_r <= '0;
      end else if (wr_op) begin
         arith_r <= alu_flags;
      end else if (wr_flags) begin
         arith_r.sign_wrap_flag <= w_data_r[3];
         arith_r.zero <= w_data_r[2];
         arith_r.half_bit_flag <= w_data_r[1];
         arith_r.carry <= w_data_r[0];
      end
   end

   // A timeout in the same cycle as a clear still leaves the flag set.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         to_r <= 1'b0;
      end else if (wdt_timeout) begin
         to_r <= 1'b1;
      end else if (cmd_watchdog_clear_instr || cmd_halt) begin
         to_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pdf_r <= 1'b0;
      end else if (cmd_halt) begin
         pdf_r <= 1'b1;
      end else if (cmd_watchdog_clear_instr) begin
         pdf_r <= 1'b0;
      end
   end

   assign flag_word = '{sign_xor_flag: arith_r.sign_xor_flag,
                        borrow_chain_null: arith_r.borrow_chain_null,
                        wdt_expired_flag: to_r, halted_flag: pdf_r,
                        sign_wrap_flag: arith_r.sign_wrap_flag, zero: arith_r.zero,
                        half_bit_flag: arith_r.half_bit_flag, carry: arith_r.carry};

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign pc_out = pc_r;
   assign bank_out = bank_sel_r;
   assign dummy_cycle = dummy_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence pcl_then_dummy;
      dummy_r ##1 !dummy_r;
   endsequence

   sequence tread_fill;
      tread_pend_r ##1 (tread_hi_r == $past(mem_rdata[15:8]) && work_r == $past(mem_rdata[7:0]));
   endsequence

   bank_write_a: assert property (wr_bank |=> bank_sel_r == $past(w_data_r[7:0]))
      else $error("bank select lost a write");
   bank_reset_a: assert property (@(posedge clk_sys) $fell(sys_rst) |-> bank_sel_r == 8'h00 && !to_r && !pdf_r)
      else $error("bank select or system flags not zero after reset");
   jump_bank_a: assert property (wr_jump |=> pc_r[15:13] == ($past(bank_sel_r[2:0]) & BANK_MASK))
      else $error("jump target outside the selected bank");
   pcl_dummy_a: assert property (wr_pcl && !wr_jump |=> pc_r[7:0] == $past(w_data_r[7:0]) && pc_r[15:8] == $past(pc_r[15:8]) ##0 pcl_then_dummy)
      else $error("pc low write without dummy cycle");
   tread_data_a: assert property (cmd_tread |=> tread_fill)
      else $error("table read bytes misplaced");
   move_path_a: assert property (wr_op && alu_op == cfb_core_pkg::CFB_OP_MOVM |=> result_r == $past(work_r) && $stable(work_r))
      else $error("store move did not pass the work register");
   flag_guard_a: assert property (wr_flags && !wdt_timeout |=> $stable(to_r) && $stable(pdf_r) && $stable(arith_r.sign_xor_flag))
      else $error("software write changed a read-only flag");
   to_set_a: assert property (wdt_timeout |=> to_r [*1] ##1 (to_r || $past(cmd_watchdog_clear_instr || cmd_halt)))
      else $error("expired flag not set by timeout");
   pdf_halt_a: assert property (cmd_halt |=> pdf_r && to_r == $past(wdt_timeout))
      else $error("halt did not set halted flag");
   carry_add_a: assert property (wr_op && alu_op == cfb_core_pkg::CFB_OP_ADD |=> {arith_r.carry, result_r} == {1'b0, $past(work_r)} + {1'b0, $past(w_data_r[7:0])})
      else $error("carry wrong after add");
   sign_xor_a: assert property (wr_op && alu_op inside {cfb_core_pkg::CFB_OP_ADD, cfb_core_pkg::CFB_OP_SUB} |=> arith_r.sign_xor_flag == (arith_r.sign_wrap_flag ^ result_r[7]) && arith_r.zero == (result_r == 8'h00))
      else $error("sign xor or zero flag wrong");
   chain_sub_a: assert property (wr_op && alu_op == cfb_core_pkg::CFB_OP_SBC |=> arith_r.borrow_chain_null == ($past(arith_r.borrow_chain_null) && result_r == 8'h00))
      else $error("chained zero flag wrong after borrow subtract");
endmodule
`default_nettype wire

// [tb/cfb_core_flags_tb.sv]
// Self-checking testbench for the core flag word and bank select block.
`include "cfb_core_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cfb_core_flags_tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic wdt_timeout = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, dummy_cycle;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] pc_out;
   logic [7:0] bank_out;
   int failures = 0;
   int samples_checked = 0;
   int dummy_cnt = 0;

   cfb_core_flags #(.BANK_W(3)) cfb_core_flags_i (
      .clk_sys(clk_sys), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wdt_timeout(wdt_timeout), .pc_out(pc_out), .bank_out(bank_out),
      .dummy_cycle(dummy_cycle));

   always #12.5 clk_sys = ~clk_sys;

   // Counts dummy cycles so a missing or doubled one shows up.
   always @(posedge clk_sys) begin
      if (dummy_cycle === 1'b1) dummy_cnt++;
   end

   task summarize;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Both channels are released at their own take edge; bready stays up until bvalid.
      do begin
         @(posedge clk_sys);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 40);
      r = bresp;
      bready <= 1'b0;
      if (bvalid !== 1'b1) begin
         failures++;
         summarize;
      end
      // One idle edge keeps a following call from raising bready again in this step.
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 40);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (rvalid !== 1'b1) begin
         failures++;
         summarize;
      end
      @(posedge clk_sys);
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk({30'h0, r}, {30'h0, `CFB_RESP_OK});
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d & m, e);
   endtask

   task automatic op(input logic [3:0] o, input logic [7:0] v);
      w(`CFB_OFF_OP, {20'h0_0000, o, v});
   endtask

   task automatic pulse_wdt;
      wdt_timeout <= 1'b1;
      @(posedge clk_sys);
      wdt_timeout <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic t_reset;
      rc(`CFB_OFF_BANK_SEL, 32'hFFFF_FFFF, 32'h0000_0000);
      rc(`CFB_OFF_FLAGS, 32'h0000_0030, 32'h0000_0000);
      chk({16'h0000, pc_out}, 32'h0000_0000);
      $display("reset test done");
   endtask

   task automatic t_bank;
      logic [2:0] b;
      w(`CFB_OFF_BANK_SEL, 32'h0000_00FF);
      rc(`CFB_OFF_BANK_SEL, 32'hFFFF_FFFF, 32'h0000_00FF);
      // Upper storage bits are set so they cannot leak into the bank choice.
      for (int i = 0; i < 8; i++) begin
         b = i[2:0];
         w(`CFB_OFF_BANK_SEL, {24'h00_0000, 5'h15, b});
         w(`CFB_OFF_JUMP, 32'h0000_0ABC);
         chk({16'h0000, pc_out}, {16'h0000, b, 13'h0ABC});
         chk({24'h00_0000, bank_out}, {24'h00_0000, 5'h15, b});
      end
      $display("bank test done");
   endtask

   task automatic t_pcl;
      int c0;
      w(`CFB_OFF_BANK_SEL, 32'h0000_0002);
      w(`CFB_OFF_JUMP, 32'h0000_1F00);
      c0 = dummy_cnt;
      w(`CFB_OFF_PC_LOW, 32'h0000_005A);
      repeat (3) @(posedge clk_sys);
      chk({16'h0000, pc_out}, 32'h0000_5F5A);
      chk(dummy_cnt - c0, 32'h0000_0001);
      rc(`CFB_OFF_STATE, 32'h0000_0001, 32'h0000_0000);
      w(`CFB_OFF_CMD, 32'h1 << `CFB_CMD_STEP);
      rc(`CFB_OFF_PC, 32'h0000_FFFF, 32'h0000_5F5B);
      $display("pc low test done");
   endtask

   task automatic t_alu;
      op(cfb_core_pkg::CFB_OP_MOVA, 8'h7F);
      op(cfb_core_pkg::CFB_OP_ADD, 8'h01);
      rc(`CFB_OFF_RESULT, 32'h0000_00FF, 32'h0000_0080);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_000A);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'h05);
      op(cfb_core_pkg::CFB_OP_SUB, 8'h05);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0047);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'h03);
      op(cfb_core_pkg::CFB_OP_SBC, 8'h03);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0047);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'hFF);
      op(cfb_core_pkg::CFB_OP_AND, 8'h0F);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0043);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'h03);
      op(cfb_core_pkg::CFB_OP_SBC, 8'h02);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0003);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'h01);
      op(cfb_core_pkg::CFB_OP_SBC, 8'h01);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0007);
      w(`CFB_OFF_FLAGS, 32'h0000_00F0);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'h80);
      op(cfb_core_pkg::CFB_OP_RLC, 8'h80);
      rc(`CFB_OFF_RESULT, 32'h0000_00FF, 32'h0000_0000);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0001);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'h02);
      op(cfb_core_pkg::CFB_OP_RRC, 8'h02);
      rc(`CFB_OFF_RESULT, 32'h0000_00FF, 32'h0000_0081);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0000);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'hF0);
      op(cfb_core_pkg::CFB_OP_XOR, 8'hF0);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0004);
      op(cfb_core_pkg::CFB_OP_OR, 8'h81);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0080);
      op(cfb_core_pkg::CFB_OP_MOVM, 8'h00);
      rc(`CFB_OFF_RESULT, 32'h0000_00FF, 32'h0000_0081);
      rc(`CFB_OFF_WORK, 32'h0000_00FF, 32'h0000_0081);
      // The sign xor bit must survive a software write that carries a zero for it.
      w(`CFB_OFF_FLAGS, 32'h0000_0001);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0081);
      op(cfb_core_pkg::CFB_OP_MOVA, 8'hFF);
      op(cfb_core_pkg::CFB_OP_ADC, 8'h00);
      rc(`CFB_OFF_RESULT, 32'h0000_00FF, 32'h0000_0000);
      rc(`CFB_OFF_FLAGS, 32'h0000_00FF, 32'h0000_0007);
      $display("flag test done");
   endtask

   task automatic t_wdt;
      pulse_wdt;
      rc(`CFB_OFF_FLAGS, 32'h0000_0030, 32'h0000_0020);
      w(`CFB_OFF_CMD, 32'h1 << `CFB_CMD_HALT);
      rc(`CFB_OFF_FLAGS, 32'h0000_0030, 32'h0000_0010);
      w(`CFB_OFF_FLAGS, 32'h0000_0020);
      rc(`CFB_OFF_FLAGS, 32'h0000_0030, 32'h0000_0010);
      pulse_wdt;
      rc(`CFB_OFF_FLAGS, 32'h0000_0030, 32'h0000_0030);
      w(`CFB_OFF_CMD, 32'h1 << `CFB_CMD_WATCHDOG_CLEAR_INSTR);
      rc(`CFB_OFF_FLAGS, 32'h0000_0030, 32'h0000_0000);
      // A timeout that lasts through the halt must leave the expired flag set.
      wdt_timeout <= 1'b1;
      w(`CFB_OFF_CMD, 32'h1 << `CFB_CMD_HALT);
      wdt_timeout <= 1'b0;
      rc(`CFB_OFF_FLAGS, 32'h0000_0030, 32'h0000_0030);
      w(`CFB_OFF_CMD, 32'h1 << `CFB_CMD_WATCHDOG_CLEAR_INSTR);
      rc(`CFB_OFF_FLAGS, 32'h0000_0030, 32'h0000_0000);
      $display("watchdog test done");
   endtask

   task automatic t_table;
      w(`CFB_OFF_MEM, 32'h0005_A55A);
      w(`CFB_OFF_MEM, 32'h0105_3CC3);
      w(`CFB_OFF_TPTR_LO, 32'h0000_0005);
      w(`CFB_OFF_TPTR_HI, 32'h0000_0001);
      w(`CFB_OFF_CMD, 32'h1 << `CFB_CMD_TREAD);
      rc(`CFB_OFF_TREAD_HI, 32'h0000_00FF, 32'h0000_003C);
      rc(`CFB_OFF_WORK, 32'h0000_00FF, 32'h0000_00C3);
      $display("table test done");
   endtask

   task automatic t_unmapped;
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h3C, 32'h0000_00FF, r);
      chk({30'h0, r}, {30'h0, `CFB_RESP_ERR});
      rd(8'h3C, d, r);
      chk({30'h0, r}, {30'h0, `CFB_RESP_ERR});
      chk(d, 32'h0000_0000);
      $display("unmapped test done");
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_reset;
      t_bank;
      t_pcl;
      t_alu;
      t_wdt;
      t_table;
      // A reset in mid-run must bring bank, pc and system flags back to zero.
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_reset;
      t_unmapped;
      summarize;
   end
endmodule
`default_nettype wire
